// ==== pkg/dsp_pkg.sv ====
/*
 * Shared constants and state encodings for the dual asynchronous serial
 * port. Assumes a single system clock that feeds every channel.
 */
package dsp_pkg;

    localparam int          NUM_CH        = 2;
    localparam int          DIV_W         = 13;
    localparam int          DATA_W        = 9;
    localparam int          FRM_W         = 11;

    // frame lengths in bit-times
    localparam logic [3:0]  LEN_SHORT     = 4'ha;
    localparam logic [3:0]  LEN_LONG      = 4'hb;

    // sixteen sample ticks per bit-time
    localparam logic [3:0]  SUB_FIRST     = 4'h1;
    localparam logic [3:0]  SUB_MID       = 4'h7;
    localparam logic [3:0]  SUB_LAST      = 4'hf;
    localparam logic [3:0]  CNT_ONE       = 4'h1;
    localparam logic [3:0]  CNT_ZERO      = 4'h0;

    localparam logic [7:0]  ONES_MIN      = 8'h03;
    localparam logic [7:0]  ONES_MAX      = 8'hff;

    localparam logic [1:0]  FIFO_DEPTH    = 2'h2;

    // receive flag bits
    localparam int          F_RDRF        = 0;
    localparam int          F_ORUN        = 1;
    localparam int          F_FE          = 2;
    localparam int          F_PF          = 3;

    // transmit flag bits
    localparam int          T_TRANSMIT_EMPTY_FLAG        = 0;
    localparam int          T_TC          = 1;
    localparam logic [1:0]  TX_FLAGS_RST  = 2'h3;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PRE  = 2'b01,
        TX_DATA = 2'b11,
        TX_BRK  = 2'b10
    } dsp_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01
    } dsp_rx_e;

endpackage

// ==== design/dsp_top.sv ====
/*
 * Dual asynchronous serial port: one serial channel module and the top
 * that places two of them side by side. Control bits arrive as plain
 * levels, register accesses as one-cycle strobes, all synchronous to
 * core_clk. The pin wire level is resolved outside from out and oe.
 */
`timescale 1ns/1ps

// What this block does
// - Two identical independent full-duplex channels, each with own pins.
// - Transmitter and receiver run apart but share format and baud rate.
// - Transmit and receive paths double buffered beside their shifters.
// - Per channel: baud control, control one, status and data groups.
// - Rewriting an unchanged control value disturbs nothing.
// - Hardware may clear the receiver wakeup bit itself.
// - Transmit flags clear by status read, then data write.
// - Receive flags clear by status read, then data read.
// - Status-plus-data read clears receive flags, never transmit flags.
// - Flags set after the status read survive the data access.
// - Reading either status byte arms every set flag.
// - Data access reads receive holding, writes transmit holding.
// - Holding word enters shifter with start, stop, parity framing.
// - Pins are serial while enabled, otherwise general I/O.
// - Open-drain select applies to both pins in every use.
// - A bit-time is one baud period.
// - Start bit needs three one-samples before the falling edge.
// - Idle frames all ones, break frames all zeros, full length.
// - Frame-length bit selects ten- or eleven-bit frames.
// - Data goes least significant bit first, same format both ends.
// - Polled flags or interrupt requests gated by enable bits.
// - Baud is clock over 32 times divisor; zero stops it.
// - Sixteen samples per bit, resynchronised on line transitions.
// - Parity in top data bit, even or odd by select.
module dsp_chan
    import dsp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [DIV_W-1:0]  baud_div,
    input  wire logic              frame_long,
    input  wire logic              par_en,
    input  wire logic              par_odd,
    input  wire logic              tx_en,
    input  wire logic              rx_en,
    input  wire logic              send_break,
    input  wire logic              rwu_wr,
    input  wire logic              rwu_wdata,
    input  wire logic [2:0]        irq_en,
    input  wire logic              open_drain,
    input  wire logic              gpio_dir_tx,
    input  wire logic              gpio_dir_rx,
    input  wire logic              gpio_out_tx,
    input  wire logic              gpio_out_rx,
    input  wire logic [1:0]        stat_rd,
    input  wire logic              data_rd,
    input  wire logic              data_wr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata,
    output logic      [1:0]        tx_flags,
    output logic      [3:0]        rx_flags,
    output logic                   receiver_wakeup_bit,
    output logic                   irq_req,
    output logic                   tx_pin_out,
    output logic                   tx_pin_oe,
    output logic                   rx_pin_out,
    output logic                   rx_pin_oe,
    input  wire logic              rx_pin_in
);

    typedef struct packed {
        logic [DIV_W-1:0]            bcnt;
        logic                        btgl;
        logic                        tick;
        logic                        te_r;
        logic                        re_r;
        logic                        te_d;
        dsp_tx_e                     tst;
        logic [3:0]                  tsub;
        logic [3:0]                  tcnt;
        logic [FRM_W-1:0]            tsh;
        logic                        txd;
        logic                        pend_pre;
        logic [DATA_W-1:0]           thold;
        logic [1:0]                  tflg;
        logic [1:0]                  tarm;
        dsp_rx_e                     rst;
        logic [3:0]                  rsub;
        logic [3:0]                  rcnt;
        logic [FRM_W-1:0]            rbits;
        logic                        rprev;
        logic [7:0]                  ones;
        logic [3:0]                  rflg;
        logic [3:0]                  rarm;
        logic [1:0][DATA_W-1:0]      mem;
        logic                        wp;
        logic                        rp;
        logic [1:0]                  cnt;
        logic                        receiver_wakeup_bit;
    } dsp_chan_s;

    dsp_chan_s s_r;
    dsp_chan_s s_nxt;

    // returns {oe, out}; open drain only ever pulls low
    function automatic logic [1:0] pin_drive(input logic od, input logic v);
        pin_drive = {(od ? ~v : 1'b1), v};
    endfunction

    // puts the parity bit into the top data bit of the frame
    function automatic logic [DATA_W-1:0] with_parity(
        input logic [DATA_W-1:0] d,
        input logic              lng,
        input logic              pe,
        input logic              odd
    );
        logic [DATA_W-1:0] r;
        r = d;
        if (pe && lng) begin
            r[8] = (^d[7:0]) ^ odd;
        end else if (pe) begin
            r[7] = (^d[6:0]) ^ odd;
        end
        if (!lng) begin
            r[8] = 1'b0;
        end
        with_parity = r;
    endfunction

    always_comb begin
        logic [3:0]        flen;
        logic [1:0]        tarm_eff;
        logic [3:0]        rarm_eff;
        logic [1:0]        tclr;
        logic [3:0]        rclr;
        logic [1:0]        tset;
        logic [3:0]        rset;
        logic              push;
        logic              pop;
        logic              done;
        logic              stop;
        logic [DATA_W-1:0] rdat;
        logic [DATA_W-1:0] tdat;
        s_nxt = s_r;
        flen = frame_long ? LEN_LONG : LEN_SHORT;
        tset = '0;
        rset = '0;
        push = 1'b0;
        done = 1'b0;
        stop = 1'b0;
        rdat = '0;
        tarm_eff = '0;
        rarm_eff = '0;
        tclr = '0;
        rclr = '0;
        pop = 1'b0;
        tdat = with_parity(s_r.thold, frame_long, par_en, par_odd);
        // enables are sampled copies; te_r acts as a level, te_d marks its rising edge
        s_nxt.te_r = tx_en;
        s_nxt.re_r = rx_en;
        s_nxt.te_d = s_r.te_r;

        // sample clock at fsys/(2*div), i.e. 16x the baud rate
        s_nxt.tick = 1'b0;
        if (baud_div == '0) begin
            s_nxt.bcnt = '0;
            s_nxt.btgl = 1'b0;
        end else if (s_r.bcnt >= baud_div - 1'b1) begin
            s_nxt.bcnt = '0;
            s_nxt.btgl = ~s_r.btgl;
            s_nxt.tick = s_r.btgl;
        end else begin
            s_nxt.bcnt = s_r.bcnt + 1'b1;
        end

        // status read arms exactly the flags it saw set
        tarm_eff = (|stat_rd) ? s_r.tflg : s_r.tarm;
        rarm_eff = (|stat_rd) ? s_r.rflg : s_r.rarm;
        if (|stat_rd) begin
            s_nxt.tarm = s_r.tflg;
            s_nxt.rarm = s_r.rflg;
        end
        tclr = data_wr ? tarm_eff : 2'b00;
        rclr = data_rd ? rarm_eff : 4'h0;
        if (data_wr) begin
            s_nxt.tarm = 2'b00;
            s_nxt.thold = wdata;
        end
        if (data_rd) begin
            s_nxt.rarm = 4'h0;
        end
        pop = rclr[F_RDRF] && (s_r.cnt != 2'h0);

        // transmitter
        if (s_r.te_r && !s_r.te_d) begin
            s_nxt.pend_pre = 1'b1;
        end
        if (s_r.tick && s_r.tst != TX_IDLE) begin
            s_nxt.tsub = s_r.tsub + 1'b1;
            if (s_r.tsub == SUB_LAST) begin
                s_nxt.tsh = {1'b1, s_r.tsh[FRM_W-1:1]};
                s_nxt.tcnt = s_r.tcnt - 1'b1;
                if (s_r.tcnt == CNT_ONE) begin
                    s_nxt.tst = TX_IDLE;
                    done = 1'b1;
                    if (s_r.tst == TX_BRK && !(send_break && s_r.te_r)) begin
                        // one mark bit so the next start bit is seen
                        s_nxt.tst = TX_PRE;
                        s_nxt.tsh = '1;
                        s_nxt.tcnt = CNT_ONE;
                        done = 1'b0;
                    end
                end
            end
        end
        if (s_r.tst == TX_IDLE && s_r.te_r) begin
            s_nxt.tsub = '0;
            s_nxt.tcnt = flen;
            // first enabled cycle sends the preamble ahead of any data
            if (s_r.pend_pre || !s_r.te_d) begin
                s_nxt.tst = TX_PRE;
                s_nxt.tsh = '1;
                s_nxt.pend_pre = 1'b0;
            end else if (send_break) begin
                s_nxt.tst = TX_BRK;
                s_nxt.tsh = '0;
            end else if (!s_r.tflg[T_TRANSMIT_EMPTY_FLAG]) begin
                s_nxt.tst = TX_DATA;
                s_nxt.tsh = frame_long ? {1'b1, tdat, 1'b0}
                                       : {2'b11, tdat[7:0], 1'b0};
                tset[T_TRANSMIT_EMPTY_FLAG] = 1'b1;
            end
        end
        if (!s_r.te_r && s_r.tst == TX_IDLE) begin
            s_nxt.pend_pre = 1'b0;
        end
        if (done && !s_r.pend_pre && !send_break
            && (s_r.tflg[T_TRANSMIT_EMPTY_FLAG] || !s_r.te_r)) begin
            tset[T_TC] = 1'b1;
        end
        s_nxt.txd = (s_nxt.tst == TX_IDLE) ? 1'b1 : s_nxt.tsh[0];

        // receiver, same tick and frame length as the transmitter
        if (!s_r.re_r) begin
            s_nxt.rst = RX_IDLE;
            s_nxt.ones = '0;
        end else if (s_r.tick) begin
            s_nxt.rprev = rx_pin_in;
            if (s_r.rst == RX_IDLE) begin
                if (rx_pin_in) begin
                    if (s_r.ones != ONES_MAX) begin
                        s_nxt.ones = s_r.ones + 1'b1;
                    end
                    // a whole idle frame wakes a sleeping receiver
                    if (s_r.receiver_wakeup_bit && s_r.ones == {4'h0, flen} << 4) begin
                        s_nxt.receiver_wakeup_bit = 1'b0;
                    end
                end else begin
                    if (s_r.ones >= ONES_MIN) begin
                        s_nxt.rst = RX_SHIFT;
                        s_nxt.rsub = SUB_FIRST;
                        s_nxt.rcnt = CNT_ZERO;
                    end
                    s_nxt.ones = '0;
                end
            end else begin
                s_nxt.rsub = s_r.rsub + 1'b1;
                if (rx_pin_in != s_r.rprev) begin
                    s_nxt.rsub = SUB_FIRST;
                end
                if (s_r.rsub == SUB_MID) begin
                    if (s_r.rcnt == CNT_ZERO && rx_pin_in) begin
                        s_nxt.rst = RX_IDLE;
                    end else begin
                        s_nxt.rbits[s_r.rcnt] = rx_pin_in;
                        s_nxt.rcnt = s_r.rcnt + 1'b1;
                        if (s_r.rcnt == flen - CNT_ONE) begin
                            s_nxt.rst = RX_IDLE;
                            stop = rx_pin_in;
                            rdat = frame_long ? s_nxt.rbits[9:1]
                                 : {1'b0, s_nxt.rbits[8:1]};
                            if (!s_r.receiver_wakeup_bit) begin
                                // full buffer: word dropped, overrun
                                push = (s_r.cnt != FIFO_DEPTH);
                                rset[F_ORUN] = !push;
                                rset[F_FE] = !stop;
                                rset[F_PF] = par_en &&
                                    (with_parity(rdat, frame_long, 1'b1,
                                                 par_odd) != rdat);
                            end
                        end
                    end
                end
            end
        end
        if (rwu_wr) begin
            s_nxt.receiver_wakeup_bit = rwu_wdata;
        end

        // two-entry holding buffer, shifter side pushes
        if (push) begin
            s_nxt.mem[s_r.wp] = rdat;
            s_nxt.wp = ~s_r.wp;
        end
        if (pop) begin
            s_nxt.rp = ~s_r.rp;
        end
        case ({push, pop})
            2'b10:   s_nxt.cnt = s_r.cnt + 1'b1;
            2'b01:   s_nxt.cnt = s_r.cnt - 1'b1;
            default: s_nxt.cnt = s_r.cnt;
        endcase

        // set wins over clear
        s_nxt.tflg = (s_r.tflg & ~tclr) | tset;
        s_nxt.rflg[3:1] = (s_r.rflg[3:1] & ~rclr[3:1]) | rset[3:1];
        s_nxt.rflg[F_RDRF] = (s_nxt.cnt != 2'h0);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.tflg <= TX_FLAGS_RST;
            s_r.txd <= 1'b1;
            s_r.rprev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // four software-visible groups: two controls, status, data
    assign rdata = s_r.mem[s_r.rp];
    assign tx_flags = s_r.tflg;
    assign rx_flags = s_r.rflg;
    assign receiver_wakeup_bit = s_r.receiver_wakeup_bit;
    assign irq_req = |(irq_en & {s_r.rflg[F_RDRF], s_r.tflg[T_TC],
                                 s_r.tflg[T_TRANSMIT_EMPTY_FLAG]});

    // shifter keeps the pin until its last frame is out
    always_comb begin
        if (s_r.te_r || s_r.tst != TX_IDLE) begin
            {tx_pin_oe, tx_pin_out} = pin_drive(open_drain, s_r.txd);
        end else if (gpio_dir_tx) begin
            {tx_pin_oe, tx_pin_out} = pin_drive(open_drain, gpio_out_tx);
        end else begin
            {tx_pin_oe, tx_pin_out} = 2'b00;
        end
        if (!s_r.re_r && gpio_dir_rx) begin
            {rx_pin_oe, rx_pin_out} = pin_drive(open_drain, gpio_out_rx);
        end else begin
            {rx_pin_oe, rx_pin_out} = 2'b00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_transmit_empty_flag_clear;
        $fell(s_r.tflg[T_TRANSMIT_EMPTY_FLAG]) |-> $past(data_wr);
    endproperty
    a_transmit_empty_flag_clear: assert property (p_transmit_empty_flag_clear)
        else $error("transmit empty cleared without data write");

    property p_fe_clear;
        $fell(s_r.rflg[F_FE]) |-> $past(data_rd) && $past(s_r.rflg[F_FE]);
    endproperty
    a_fe_clear: assert property (p_fe_clear)
        else $error("framing flag cleared without data read");

    property p_longword_keeps_tc;
        data_rd && !data_wr && s_r.tflg[T_TC] |=> s_r.tflg[T_TC];
    endproperty
    a_longword_keeps_tc: assert property (p_longword_keeps_tc)
        else $error("data read cleared transmit complete");

    property p_late_set_kept;
        !s_r.rarm[F_PF] && s_r.rflg[F_PF] && stat_rd == 2'b00
            |=> s_r.rflg[F_PF];
    endproperty
    a_late_set_kept: assert property (p_late_set_kept)
        else $error("unarmed parity flag was cleared");

    property p_byte_arms;
        stat_rd == 2'b01 && s_r.rflg[F_ORUN] && !data_rd
            |=> s_r.rarm[F_ORUN];
    endproperty
    a_byte_arms: assert property (p_byte_arms)
        else $error("low byte status read did not arm overrun");

    property p_div_zero;
        baud_div == '0 ##1 baud_div == '0 |=> !s_r.tick;
    endproperty
    a_div_zero: assert property (p_div_zero)
        else $error("sample tick with zero divisor");

    property p_start_needs_ones;
        s_r.rst == RX_IDLE ##1 s_r.rst == RX_SHIFT
            |-> $past(s_r.ones) >= ONES_MIN;
    endproperty
    a_start_needs_ones: assert property (p_start_needs_ones)
        else $error("start accepted after too few idle samples");

    property p_start_bit_low;
        s_r.tst == TX_IDLE ##1 s_r.tst == TX_DATA |-> !s_r.txd;
    endproperty
    a_start_bit_low: assert property (p_start_bit_low)
        else $error("data frame did not open with a start bit");

    property p_bit_stable;
        s_r.tst != TX_IDLE && !s_r.tick |=> $stable(s_r.txd);
    endproperty
    a_bit_stable: assert property (p_bit_stable)
        else $error("transmit line moved between sample ticks");

    property p_gpio_after_off;
        !s_r.te_r && s_r.tst == TX_IDLE && !gpio_dir_tx |-> !tx_pin_oe;
    endproperty
    a_gpio_after_off: assert property (p_gpio_after_off)
        else $error("transmit pin driven while released");

endmodule

module dsp_top
    import dsp_pkg::*;
(
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    input  wire logic [NUM_CH-1:0][DIV_W-1:0]   baud_div,
    input  wire logic [NUM_CH-1:0]              frame_long,
    input  wire logic [NUM_CH-1:0]              par_en,
    input  wire logic [NUM_CH-1:0]              par_odd,
    input  wire logic [NUM_CH-1:0]              tx_en,
    input  wire logic [NUM_CH-1:0]              rx_en,
    input  wire logic [NUM_CH-1:0]              send_break,
    input  wire logic [NUM_CH-1:0]              rwu_wr,
    input  wire logic [NUM_CH-1:0]              rwu_wdata,
    input  wire logic [NUM_CH-1:0][2:0]         irq_en,
    input  wire logic [NUM_CH-1:0]              open_drain,
    input  wire logic [NUM_CH-1:0]              gpio_dir_tx,
    input  wire logic [NUM_CH-1:0]              gpio_dir_rx,
    input  wire logic [NUM_CH-1:0]              gpio_out_tx,
    input  wire logic [NUM_CH-1:0]              gpio_out_rx,
    input  wire logic [NUM_CH-1:0][1:0]         stat_rd,
    input  wire logic [NUM_CH-1:0]              data_rd,
    input  wire logic [NUM_CH-1:0]              data_wr,
    input  wire logic [NUM_CH-1:0][DATA_W-1:0]  wdata,
    output logic      [NUM_CH-1:0][DATA_W-1:0]  rdata,
    output logic      [NUM_CH-1:0][1:0]         tx_flags,
    output logic      [NUM_CH-1:0][3:0]         rx_flags,
    output logic      [NUM_CH-1:0]              receiver_wakeup_bit,
    output logic      [NUM_CH-1:0]              irq_req,
    output logic      [NUM_CH-1:0]              tx_pin_out,
    output logic      [NUM_CH-1:0]              tx_pin_oe,
    output logic      [NUM_CH-1:0]              rx_pin_out,
    output logic      [NUM_CH-1:0]              rx_pin_oe,
    input  wire logic [NUM_CH-1:0]              rx_pin_in
);

    // index 0 is serial_channel_a, index 1 serial_channel_b
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        dsp_chan u_chan (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .baud_div    (baud_div[c]),
            .frame_long  (frame_long[c]),
            .par_en      (par_en[c]),
            .par_odd     (par_odd[c]),
            .tx_en       (tx_en[c]),
            .rx_en       (rx_en[c]),
            .send_break  (send_break[c]),
            .rwu_wr      (rwu_wr[c]),
            .rwu_wdata   (rwu_wdata[c]),
            .irq_en      (irq_en[c]),
            .open_drain  (open_drain[c]),
            .gpio_dir_tx (gpio_dir_tx[c]),
            .gpio_dir_rx (gpio_dir_rx[c]),
            .gpio_out_tx (gpio_out_tx[c]),
            .gpio_out_rx (gpio_out_rx[c]),
            .stat_rd     (stat_rd[c]),
            .data_rd     (data_rd[c]),
            .data_wr     (data_wr[c]),
            .wdata       (wdata[c]),
            .rdata       (rdata[c]),
            .tx_flags    (tx_flags[c]),
            .rx_flags    (rx_flags[c]),
            .receiver_wakeup_bit         (receiver_wakeup_bit[c]),
            .irq_req     (irq_req[c]),
            .tx_pin_out  (tx_pin_out[c]),
            .tx_pin_oe   (tx_pin_oe[c]),
            .rx_pin_out  (rx_pin_out[c]),
            .rx_pin_oe   (rx_pin_oe[c]),
            .rx_pin_in   (rx_pin_in[c])
        );
    end

endmodule


// ==== verification/dsp_far_uart.sv ====
/* remote serial device model: 8 data, no parity, one stop.
   assumes bit time given in core_clk cycles, line pulled up. */
`timescale 1ns/1ps
module dsp_far_uart #(
    parameter int BT = 32
) (
    input  wire logic core_clk,
    input  wire logic rxd,
    output logic      txd
);
    logic [7:0] got [$];
    logic [7:0] sh;
    initial txd = 1'b1;
    task automatic send(input logic [7:0] b);
        txd <= 1'b0;
        repeat (BT) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            txd <= b[i];
            repeat (BT) @(posedge core_clk);
        end
        txd <= 1'b1;
        repeat (BT) @(posedge core_clk);
    endtask
    // sample mid-bit; idle frames carry no edge so are skipped
    initial forever begin
        @(negedge rxd);
        repeat (BT / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge core_clk);
            sh[i] = rxd;
        end
        repeat (BT) @(posedge core_clk);
        got.push_back(sh);
    end
endmodule

// ==== verification/dsp_top_tb.sv ====
/* self-checking bench for the dual serial port.
   assumes channel a looped to the remote model, channel b as io, then looped to itself. */
`timescale 1ns/1ps
module dsp_top_tb
    import dsp_pkg::*;
;
    logic                          core_clk = 1'b0;
    logic                          rst_n = 1'b0;
    logic [NUM_CH-1:0][DIV_W-1:0]  baud_div;
    logic [NUM_CH-1:0][2:0]        irq_en;
    logic [NUM_CH-1:0][1:0]        stat_rd, tx_flags;
    logic [NUM_CH-1:0][3:0]        rx_flags;
    logic [NUM_CH-1:0][DATA_W-1:0] wdata, rdata;
    logic [NUM_CH-1:0] frame_long, par_en, par_odd, tx_en, rx_en;
    logic [NUM_CH-1:0] send_break, rwu_wr, rwu_wdata, open_drain;
    logic [NUM_CH-1:0] gpio_dir_tx, gpio_dir_rx, gpio_out_tx, gpio_out_rx;
    logic [NUM_CH-1:0] data_rd, data_wr, receiver_wakeup_bit, irq_req, rx_pin_in;
    logic [NUM_CH-1:0] tx_pin_out, tx_pin_oe, rx_pin_out, rx_pin_oe;
    logic              line_a, line_b, far_tx;
    int                miscompares = 0;
    int                tests_run = 0;
    int                n;
    // pull-up holds the line high when released
    assign line_a = tx_pin_oe[0] ? tx_pin_out[0] : 1'b1;
    // channel b talks to itself over its open-drain line
    assign line_b = tx_pin_oe[1] ? tx_pin_out[1] : 1'b1;
    assign rx_pin_in = {line_b, far_tx};
    always #2.5 core_clk = ~core_clk;
    dsp_top dut_u (.*);
    dsp_far_uart #(.BT(32)) far_u (
        .core_clk(core_clk), .rxd(line_a), .txd(far_tx));
    task automatic chk(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input int ch, input logic [1:0] s, input logic r,
                       input logic w, input logic [8:0] d);
        @(posedge core_clk);
        stat_rd[ch] <= s;
        data_rd[ch] <= r;
        data_wr[ch] <= w;
        wdata[ch] <= d;
        @(posedge core_clk);
        stat_rd[ch] <= 2'h0;
        data_rd[ch] <= 1'b0;
        data_wr[ch] <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task complete_run;
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {baud_div, irq_en, stat_rd, wdata} = '0;
        {frame_long, par_en, par_odd, tx_en, rx_en, send_break} = '0;
        {rwu_wr, rwu_wdata, gpio_out_rx, data_rd, data_wr} = '0;
        {open_drain, gpio_dir_tx, gpio_out_tx, gpio_dir_rx} = 8'haa;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("tx_flags", tx_flags[0], 9'h003);
        chk("rx_flags", rx_flags[0], 9'h000);
        chk("tx_oe_a", tx_pin_oe[0], 9'h000);
        chk("tx_oe_b", tx_pin_oe[1], 9'h000);
        chk("rx_oe_b", {rx_pin_oe[1], rx_pin_out[1]}, 9'h002);
        chk("irq_a", irq_req[0], 9'h000);
        baud_div[0] <= 13'h1;
        @(posedge core_clk);
        tx_en[0] <= 1'b1;
        rx_en[0] <= 1'b1;
        acc(0, 2'h1, 1'b0, 1'b0, 9'h000);
        acc(0, 2'h0, 1'b0, 1'b1, 9'h05a);
        chk("tx_flags", tx_flags[0], 9'h000);
        chk("tx_oe_a", tx_pin_oe[0], 9'h001);
        for (n = 0; n < 2000 && tx_flags[0][0] !== 1'b1; n++)
            @(posedge core_clk);
        chk("transmit_empty_flag", tx_flags[0], 9'h001);
        acc(0, 2'h1, 1'b0, 1'b0, 9'h000);
        acc(0, 2'h0, 1'b0, 1'b1, 9'h0a5);
        for (n = 0; n < 3000 && far_u.got.size() < 2; n++)
            @(posedge core_clk);
        chk("tx_word0", far_u.got[0], 9'h05a);
        chk("tx_word1", far_u.got[1], 9'h0a5);
        for (n = 0; n < 500 && tx_flags[0][1] !== 1'b1; n++)
            @(posedge core_clk);
        chk("tx_flags", tx_flags[0], 9'h003);
        acc(0, 2'h0, 1'b0, 1'b1, 9'h0ff);
        chk("tx_flags", tx_flags[0], 9'h003);
        far_u.send(8'h3c);
        far_u.send(8'hc3);
        chk("rdata", rdata[0], 9'h03c);
        acc(0, 2'h0, 1'b1, 1'b0, 9'h000);
        chk("rdata", rdata[0], 9'h03c);
        acc(0, 2'h2, 1'b1, 1'b0, 9'h000);
        chk("rdata", rdata[0], 9'h0c3);
        chk("tx_flags", tx_flags[0], 9'h003);
        acc(0, 2'h1, 1'b1, 1'b0, 9'h000);
        chk("rx_flags", rx_flags[0], 9'h000);
        repeat (3) far_u.send(8'h11);
        chk("overrun", rx_flags[0][1], 9'h001);
        irq_en[0] <= 3'h4;
        rwu_wr[0] <= 1'b1;
        rwu_wdata[0] <= 1'b1;
        @(posedge core_clk);
        rwu_wr[0] <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("irq_a", irq_req[0], 9'h001);
        chk("rwu", receiver_wakeup_bit[0], 9'h001);
        // a full idle frame of ones lets hardware wake the receiver
        repeat (400) @(posedge core_clk);
        chk("rwu", receiver_wakeup_bit[0], 9'h000);
        // channel a is finished, so it may be switched off
        tx_en[0] <= 1'b0;
        rx_en[0] <= 1'b0;
        frame_long[1] <= 1'b1;
        par_en[1] <= 1'b1;
        par_odd[1] <= 1'b1;
        baud_div[1] <= 13'h1;
        acc(1, 2'h1, 1'b0, 1'b0, 9'h000);
        acc(1, 2'h0, 1'b0, 1'b1, 9'h0a5);
        chk("tx_oe_a", tx_pin_oe[0], 9'h000);
        tx_en[1] <= 1'b1;
        rx_en[1] <= 1'b1;
        for (n = 0; n < 2000 && rx_flags[1][0] !== 1'b1; n++)
            @(posedge core_clk);
        // four ones in the byte, so odd parity puts a one on top
        chk("rdata_b", rdata[1], 9'h1a5);
        chk("rx_flags_b", rx_flags[1], 9'h001);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        complete_run;
    end
endmodule
